// ---- core/bwf_regs.svh ----
/*
  Named constants for the byte-wide FIFO host port: widths, depths,
  FIFO level figures and reset values.
  Assumes inclusion by bare name from core/ sources only.
*/
`ifndef BWF_REGS_SVH
`define BWF_REGS_SVH

// Byte bus width
`define BWF_DATA_W 8
// Depth of each internal FIFO in bytes
`define BWF_FIFO_DEPTH 32
// Width of a FIFO level count (log2 of depth plus one)
`define BWF_LEVEL_W 6
`define BWF_LEVEL_EMPTY 6'h00
`define BWF_LEVEL_ONE 6'h01
`define BWF_LEVEL_FULL 6'h20
// Reset values
`define BWF_STROBE_IDLE 1'b1
`define BWF_BYTE_RESET 8'h00
`define BWF_CLK_RESET 1'b0
`define BWF_RST_ACTIVE 1'b0
`define BWF_RST_DONE 1'b1

`endif

// ---- core/bwf_pkg.sv ----
/*
  Types shared by the byte-wide FIFO host port modules.
  Assumes bwf_regs.svh is on the include path.
*/
`include "bwf_regs.svh"

package bwf_pkg;

  typedef logic [`BWF_DATA_W-1:0] bwf_byte_t;
  typedef logic [`BWF_LEVEL_W-1:0] bwf_level_t;

endpackage : bwf_pkg

// ---- core/bwf_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides and a fill level.
  Assumes one clock, a synchronous-release active-low reset and a clock enable.
*/
`timescale 1ns/1ps

module bwf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Status
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] level_reg;

  wire push = en & in_valid & in_ready;
  wire pop = en & out_valid & out_ready;
  wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
  wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;

  assign in_ready = (level_reg != FULL_LEVEL);
  assign out_valid = (level_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign level = level_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_next;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end

endmodule : bwf_fifo

// ---- core/bwf_host_port.sv ----
/*
  Byte-wide parallel FIFO port between an external host and the device core.
  The host writes bytes into a transmit FIFO drained by the core, and reads
  bytes from a receive FIFO filled by the core.
  Assumes host strobes are synchronous to ref_clk and each strobe level lasts
  at least one enabled cycle; the pad ring resolves the shared bus wire.
*/
`timescale 1ns/1ps
`include "bwf_regs.svh"

module bwf_host_port
  import bwf_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Variant select: high for the synchronous FIFO variant
  input wire logic sync_mode,
  // Host byte bus, split into its three signals
  input wire bwf_byte_t byte_bus_lines_i,
  output bwf_byte_t byte_bus_lines_o,
  output logic byte_bus_lines_oe,
  // Host strobes, active low
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic host_oe_n,
  // Host status flags, active low
  output logic tx_space_n,
  output logic rx_avail_n,
  // Clock for the synchronous variant
  output logic host_clk_out,
  // Core side: bytes written by the host
  output bwf_byte_t tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Core side: bytes for the host to read
  input wire bwf_byte_t rx_data,
  input wire logic rx_valid,
  output logic rx_ready
);

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire rst_sync_n = rst_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= `BWF_RST_ACTIVE;
      rst_sync_reg <= `BWF_RST_ACTIVE;
    end else begin
      rst_meta_reg <= `BWF_RST_DONE;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Strobe edge detection
  logic wr_prev_reg;
  logic rd_prev_reg;
  wire wr_fall = clk_en & wr_prev_reg & ~host_wr_n;
  wire rd_fall = clk_en & rd_prev_reg & ~host_rd_n;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_prev_reg <= `BWF_STROBE_IDLE;
      rd_prev_reg <= `BWF_STROBE_IDLE;
    end else if (clk_en) begin
      wr_prev_reg <= host_wr_n;
      rd_prev_reg <= host_rd_n;
    end
  end

  // Transmit FIFO: filled by host writes, drained by the core
  bwf_level_t tx_level;
  logic tx_in_ready;
  wire tx_push = wr_fall & tx_in_ready;
  wire tx_pop = clk_en & tx_valid & tx_ready;

  bwf_fifo #(
    .WIDTH(`BWF_DATA_W),
    .DEPTH(`BWF_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .en(clk_en),
    .in_data(byte_bus_lines_i),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .level(tx_level)
  );

  // Writes while full are dropped; the host is told to hold off
  assign tx_space_n = ~tx_in_ready;

  // Receive FIFO: filled by the core, drained by host reads
  bwf_level_t rx_level;
  bwf_byte_t rx_head;
  logic rx_head_valid;
  wire rx_pop = rd_fall & rx_head_valid;
  wire rx_push = clk_en & rx_valid & rx_ready;

  bwf_fifo #(
    .WIDTH(`BWF_DATA_W),
    .DEPTH(`BWF_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .en(clk_en),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(rx_head),
    .out_valid(rx_head_valid),
    .out_ready(rx_pop),
    .level(rx_level)
  );

  assign rx_avail_n = ~rx_head_valid;

  // Byte presented to the host, fetched on the read strobe edge
  bwf_byte_t out_byte_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_byte_reg <= `BWF_BYTE_RESET;
    end else if (rx_pop) begin
      out_byte_reg <= rx_head;
    end
  end

  assign byte_bus_lines_o = out_byte_reg;

  // Bus drive: read strobe low, and output enable low in synchronous variant
  wire oe_gate_ok = ~sync_mode | ~host_oe_n;
  assign byte_bus_lines_oe = ~host_rd_n & oe_gate_ok;

  // Clock output for the synchronous variant, half of ref_clk
  logic clk_div_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clk_div_reg <= `BWF_CLK_RESET;
    end else if (clk_en) begin
      clk_div_reg <= sync_mode & ~clk_div_reg;
    end
  end

  assign host_clk_out = clk_div_reg;

  // Checks

  sequence s_wr_fall;
    clk_en && wr_prev_reg && !host_wr_n;
  endsequence

  sequence s_rd_fall;
    clk_en && rd_prev_reg && !host_rd_n;
  endsequence

  sequence s_tx_push_alone;
    s_wr_fall ##0 !tx_space_n ##0 !tx_pop;
  endsequence

  a_tx_full_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (tx_level == `BWF_LEVEL_FULL) |-> tx_space_n
  ) else $error("space flag low while transmit FIFO full");

  a_tx_room_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (tx_level != `BWF_LEVEL_FULL) |-> !tx_space_n
  ) else $error("space flag high with room in transmit FIFO");

  a_rx_empty_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (rx_level == `BWF_LEVEL_EMPTY) |-> rx_avail_n
  ) else $error("data flag low with receive FIFO empty");

  a_rx_avail_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (rx_level != `BWF_LEVEL_EMPTY) |-> !rx_avail_n
  ) else $error("data flag high with a byte waiting");

  a_wr_capture_byte: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    s_tx_push_alone |=> (tx_level == $past(tx_level) + `BWF_LEVEL_ONE)
  ) else $error("write strobe edge did not store a byte");

  a_wr_first_byte: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    s_wr_fall ##0 (tx_level == `BWF_LEVEL_EMPTY) |=> (tx_data == $past(byte_bus_lines_i)) && tx_valid
  ) else $error("stored byte differs from bus byte");

  a_rd_bus_drive: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (!host_rd_n && !sync_mode) |-> byte_bus_lines_oe
  ) else $error("bus not driven during read strobe");

  a_rd_fetch_next: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    s_rd_fall ##0 !rx_avail_n |=> (byte_bus_lines_o == $past(rx_head)) &&
      ($past(rx_push) ? (rx_level == $past(rx_level)) : (rx_level == $past(rx_level) - `BWF_LEVEL_ONE))
  ) else $error("read strobe edge did not fetch the next byte");

  a_oe_gate_sync: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (sync_mode && host_oe_n) |-> !byte_bus_lines_oe
  ) else $error("bus driven with output enable high");

  a_clkout_toggle: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (sync_mode && clk_en) |=> (host_clk_out != $past(host_clk_out))
  ) else $error("clock output did not toggle");

  a_clkout_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (!sync_mode && clk_en) |=> !host_clk_out
  ) else $error("clock output active in asynchronous variant");

  a_bus_release: assert property (
    @(posedge ref_clk) disable iff (!rst_sync_n)
    host_rd_n |-> !byte_bus_lines_oe
  ) else $error("bus driven while read strobe high");

endmodule : bwf_host_port

// ---- tb/bwf_host_model.sv ----
/*
  Host-side model of the byte-wide FIFO port: strobes and the bus wire.
  Assumes one caller at a time, clocked by ref_clk.
*/
`timescale 1ns/1ps

module bwf_host_model
  import bwf_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Strobes
  output logic host_wr_n,
  output logic host_rd_n,
  // Bus wire
  input wire bwf_byte_t dev_o,
  input wire logic dev_oe,
  output bwf_byte_t bus
);
  logic drv = 1'b0;
  bwf_byte_t dat = 8'h00;
  bwf_byte_t noise = 8'h00;

  initial begin
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
  end

  // Undriven bus wanders every cycle
  always @(posedge ref_clk) begin
    noise <= noise + 8'h3b;
  end
  assign bus = dev_oe ? dev_o : (drv ? dat : noise);

  task automatic wr(input bwf_byte_t b);
    @(posedge ref_clk);
    host_wr_n <= 1'b0;
    drv <= 1'b1;
    dat <= b;
    @(posedge ref_clk);
    host_wr_n <= 1'b1;
    drv <= 1'b0;
  endtask : wr

  task automatic rd(output bwf_byte_t b, output logic oe);
    @(posedge ref_clk);
    host_rd_n <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    b = bus;
    oe = dev_oe;
    @(posedge ref_clk);
    host_rd_n <= 1'b1;
  endtask : rd
endmodule : bwf_host_model

// ---- tb/byte_wide_fifo_host_port_tb.sv ----
/*
  Self-checking bench for the byte-wide FIFO host port.
  Assumes the host model on the pin side and the bench as device core.
*/
`timescale 1ns/1ps

module byte_wide_fifo_host_port_tb
  import bwf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sync_mode = 1'b0;
  logic host_oe_n = 1'b1;
  logic clk_en = 1'b1;
  logic rx_rdy;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  bwf_byte_t rx_data = 8'h00;
  bwf_byte_t bus_i, bus_o, tx_data, b;
  logic oe, wr_n, rd_n, space_n, avail_n, clk_out, tx_valid, o;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  initial forever #4 ref_clk = ~ref_clk;

  bwf_host_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .sync_mode(sync_mode),
    .byte_bus_lines_i(bus_i), .byte_bus_lines_o(bus_o), .byte_bus_lines_oe(oe), .host_wr_n(wr_n),
    .host_rd_n(rd_n), .host_oe_n(host_oe_n), .tx_space_n(space_n), .rx_avail_n(avail_n),
    .host_clk_out(clk_out), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_rdy));

  bwf_host_model host (.ref_clk(ref_clk), .host_wr_n(wr_n), .host_rd_n(rd_n), .dev_o(bus_o),
    .dev_oe(oe), .bus(bus_i));

  task automatic check(input bwf_byte_t got, input bwf_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    host.wr(8'h33);
    repeat (2) @(posedge ref_clk);
    clk_en <= 1'b1;
    @(negedge ref_clk);
    check({7'h00, tx_valid}, 8'h00);
    @(negedge ref_clk);
    check({7'h00, tx_valid}, 8'h00);
    check({7'h00, space_n}, 8'h00);
    $display("freeze test done");
  endtask : t_freeze

  task automatic t_write;
    for (int i = 0; i < 32; i++) begin
      host.wr(8'(i) ^ 8'h5a);
      @(negedge ref_clk);
      check({7'h00, space_n}, {7'h00, i == 31});
    end
    host.wr(8'hee);
    check({7'h00, oe}, 8'h00);
    @(posedge ref_clk);
    tx_ready <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(negedge ref_clk);
      check(tx_data, 8'(i) ^ 8'h5a);
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    check({7'h00, tx_valid}, 8'h00);
    @(posedge ref_clk);
    tx_ready <= 1'b0;
    $display("write test done");
  endtask : t_write

  task automatic t_read;
    check({7'h00, avail_n}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= 8'hc0 + 8'(i);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(negedge ref_clk);
    check({7'h00, avail_n}, 8'h00);
    check({7'h00, rx_rdy}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      host.rd(b, o);
      check(b, 8'hc0 + 8'(i));
      check({7'h00, o}, 8'h01);
    end
    @(negedge ref_clk);
    check({7'h00, avail_n}, 8'h01);
    check({7'h00, oe}, 8'h00);
    check({7'h00, clk_out}, 8'h00);
    host.rd(b, o);
    check(b, 8'hc2);
    $display("read test done");
  endtask : t_read

  task automatic t_sync;
    @(posedge ref_clk);
    sync_mode <= 1'b1;
    rx_valid <= 1'b1;
    rx_data <= 8'h96;
    @(posedge ref_clk);
    rx_data <= 8'h69;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    @(negedge ref_clk);
    b = {7'h00, clk_out};
    @(negedge ref_clk);
    check({7'h00, clk_out}, {7'h00, ~b[0]});
    host.rd(b, o);
    check({7'h00, o}, 8'h00);
    host_oe_n <= 1'b0;
    host.rd(b, o);
    check({7'h00, o}, 8'h01);
    check(b, 8'h69);
    @(negedge ref_clk);
    check({7'h00, avail_n}, 8'h01);
    sync_mode <= 1'b0;
    host_oe_n <= 1'b1;
    $display("sync test done");
  endtask : t_sync

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_freeze();
    t_write();
    t_read();
    t_sync();
    give_verdict();
  end
endmodule : byte_wide_fifo_host_port_tb
